// ==== hdl/pgd_pkg.sv ====
package pgd_pkg;

	// Clock and pin timing.
	localparam int CLK_HZ = 10_000_000;

	// Register byte offsets on the bus.
	localparam logic [7:0] ADR_CTRL    = 8'h00;
	localparam logic [7:0] ADR_CHAN    = 8'h04;
	localparam logic [7:0] ADR_MSG     = 8'h08;
	localparam logic [7:0] ADR_IDENT   = 8'h0C;
	localparam logic [7:0] ADR_STATUS  = 8'h10;
	localparam logic [7:0] ADR_OPTSEL  = 8'h14;
	localparam logic [7:0] ADR_OPTWORD = 8'h18;

	// Control register fields and the channel request bit.
	localparam int CTRL_RX_PWR   = 0;
	localparam int CTRL_SYN_PWR  = 1;
	localparam int CTRL_QCF      = 2;
	localparam int CTRL_QCS      = 3;
	localparam int CTRL_SYNCED   = 4;
	localparam int CTRL_ADDR_HIT = 5;
	localparam int CTRL_MSG_ACT  = 6;
	localparam int CTRL_LED_UP   = 7;
	localparam int CHAN_REQ_BIT  = 8;

	// Option chain length and the positions of the pin options.
	localparam int            OPT_BITS     = 192;
	localparam logic [7:0]    OPT_LAST     = 8'hBF;
	localparam int OPT_CLK_IDLE    = 104;
	localparam int OPT_DAT_IDLE    = 105;
	localparam int OPT_EDGE_SEL    = 106;
	localparam int OPT_RX_LEVEL    = 107;
	localparam int OPT_SYN_LEVEL   = 108;
	localparam int OPT_QCF_LEVEL   = 109;
	localparam int OPT_QCS_LEVEL   = 110;
	localparam int OPT_RATE_HI     = 113;
	localparam int OPT_RATE_LO     = 114;
	localparam int OPT_LED_FREQ    = 118;
	localparam int OPT_VALID_LEVEL = 119;
	localparam int OPT_GAP_HI      = 120;
	localparam int OPT_GAP_LO      = 121;

	// LED tone frequencies in Hz and their half periods in clock cycles.
	localparam int LED_HZ_10K = 10_000;
	localparam int LED_HZ_40K = 40_000;
	localparam int LED_HZ_4K  = 4_000;
	localparam int LED_HZ_16K = 16_000;
	localparam logic [10:0] LED_HALF_10K = 11'(CLK_HZ / (2 * LED_HZ_10K));
	localparam logic [10:0] LED_HALF_40K = 11'(CLK_HZ / (2 * LED_HZ_40K));
	localparam logic [10:0] LED_HALF_4K  = 11'(CLK_HZ / (2 * LED_HZ_4K));
	localparam logic [10:0] LED_HALF_16K = 11'(CLK_HZ / (2 * LED_HZ_16K));

	// Message clock rates in Hz, selected by the two rate option bits.
	localparam int MSG_HZ_0 = 2_400;
	localparam int MSG_HZ_1 = 4_800;
	localparam int MSG_HZ_2 = 9_600;
	localparam int MSG_HZ_3 = 19_200;
	localparam logic [11:0] MSG_HALF_0 = 12'(CLK_HZ / (2 * MSG_HZ_0));
	localparam logic [11:0] MSG_HALF_1 = 12'(CLK_HZ / (2 * MSG_HZ_1));
	localparam logic [11:0] MSG_HALF_2 = 12'(CLK_HZ / (2 * MSG_HZ_2));
	localparam logic [11:0] MSG_HALF_3 = 12'(CLK_HZ / (2 * MSG_HZ_3));

	// Gap after each byte and the length of a byte, in message clock half periods.
	localparam logic [4:0] GAP_HALVES_0 = 5'h00;
	localparam logic [4:0] GAP_HALVES_1 = 5'h02;
	localparam logic [4:0] GAP_HALVES_2 = 5'h04;
	localparam logic [4:0] GAP_HALVES_3 = 5'h08;
	localparam logic [4:0] BYTE_TOGGLES = 5'h10;

	typedef enum logic [1:0] {
		M_IDLE  = 2'b00,
		M_SHIFT = 2'b01,
		M_GAP   = 2'b10
	} pgd_msg_e;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  sel;
		logic [7:0]  adr;
		logic [31:0] dat;
	} pgd_wb_req_s;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} pgd_wb_rsp_s;

endpackage : pgd_pkg

// ==== hdl/pgd_decoder_pins.sv ====
// The Wishbone register port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none

module pgd_decoder_pins (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	output logic             wb_ack_o,
	output logic      [31:0] wb_dat_o,
	input  wire logic        chip_on_i,
	input  wire logic        decoder_reset_in_i,
	input  wire logic        option_load_clock_i,
	input  wire logic        option_serial_io_i,
	output logic             option_serial_io_o,
	output logic             option_serial_io_oe_n_o,
	input  wire logic        demod_lsb_in_i,
	input  wire logic        demod_msb_in_i,
	input  wire logic        forced_roaming_in_i,
	input  wire logic        led_clock_enable_i,
	output logic             led_clock_out_o,
	output logic             quick_charge_first_o,
	output logic             quick_charge_second_o,
	output logic             rf_ctrl_inverted_o,
	output logic             receiver_power_ctrl_o,
	output logic             synth_power_ctrl_o,
	output logic             channel_change_req_o,
	output logic             sync_indicator_o,
	output logic             own_address_hit_o,
	output logic             message_valid_o,
	output logic             message_serial_out_o,
	output logic             message_clock_o
);

	typedef struct packed {
		logic                ack;
		logic [31:0]         rdat;
		logic [7:0]          ctrl;
		logic [3:0]          chan_next;
		logic [3:0]          chan;
		logic                chg;
		logic [15:0]         ident;
		logic [2:0]          optsel;
		logic [191:0]        opts;
		logic [7:0]          idx;
		logic                loaded;
		logic [3:0]          ident_pos;
		logic                sio;
		logic                oclk_s1;
		logic                oclk_s2;
		logic                oclk_d;
		logic                sd_s1;
		logic                sd_s2;
		logic                rst_s1;
		logic                rst_s2;
		logic                on_s1;
		logic                on_s2;
		logic [1:0]          dm_s1;
		logic [1:0]          dm_s2;
		logic                fr_s1;
		logic                fr_s2;
		logic                le_s1;
		logic                le_s2;
		logic                syn_prev;
		logic [10:0]         led_cnt;
		logic                led;
		pgd_pkg::pgd_msg_e   mst;
		logic [11:0]         mcnt;
		logic [7:0]          mbyte;
		logic [2:0]          mbit;
		logic [4:0]          mtog;
		logic                msampled;
		logic                mclk;
		logic                mdat;
	} pgd_state_s;

	pgd_state_s          q;
	pgd_state_s          d;
	pgd_pkg::pgd_wb_req_s req;
	logic                oclk_rise;
	logic                wr;
	logic                opt_clk_idle;
	logic                opt_dat_idle;
	logic                opt_edge;
	logic                opt_valid_lvl;
	logic [10:0]         led_half;
	logic [11:0]         msg_half;
	logic [4:0]          gap_halves;
	logic                new_clk;

	assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
		adr: wb_adr_i, dat: wb_dat_i};
	assign opt_clk_idle  = q.opts[pgd_pkg::OPT_CLK_IDLE];
	assign opt_dat_idle  = q.opts[pgd_pkg::OPT_DAT_IDLE];
	assign opt_edge      = q.opts[pgd_pkg::OPT_EDGE_SEL];
	assign opt_valid_lvl = q.opts[pgd_pkg::OPT_VALID_LEVEL];

	always_comb
	begin
		d = q;
		wr = req.cyc & req.stb & req.we & ~q.ack;
		// Every pin from outside passes two flip-flops before use.
		d.oclk_s1 = option_load_clock_i;
		d.oclk_s2 = q.oclk_s1;
		d.oclk_d  = q.oclk_s2;
		d.sd_s1   = option_serial_io_i;
		d.sd_s2   = q.sd_s1;
		d.rst_s1  = decoder_reset_in_i;
		d.rst_s2  = q.rst_s1;
		d.on_s1   = chip_on_i;
		d.on_s2   = q.on_s1;
		d.dm_s1   = {demod_msb_in_i, demod_lsb_in_i};
		d.dm_s2   = q.dm_s1;
		d.fr_s1   = forced_roaming_in_i;
		d.fr_s2   = q.fr_s1;
		d.le_s1   = led_clock_enable_i;
		d.le_s2   = q.le_s1;
		oclk_rise = q.oclk_s2 & ~q.oclk_d & q.on_s2;

		// Option chain load, then operator identity readout on the same pin.
		if (oclk_rise && !q.loaded)
		begin
			d.opts[q.idx] = q.sd_s2;
			d.idx = q.idx + 8'h01;
			if (q.idx == pgd_pkg::OPT_LAST)
			begin
				d.loaded = 1'b1;
				d.sio = q.ident[0];
				d.ident_pos = 4'h1;
			end
		end
		else if (oclk_rise)
		begin
			d.sio = q.ident[q.ident_pos];
			d.ident_pos = q.ident_pos + 4'h1;
		end

		// Bus slave: one wait state, unmapped reads return zero.
		d.ack = req.cyc & req.stb & ~q.ack;
		d.rdat = 32'h0000_0000;
		if (wr)
		begin
			unique case (req.adr)
				pgd_pkg::ADR_CTRL:
					if (req.sel[0])
						d.ctrl = req.dat[7:0];
				pgd_pkg::ADR_CHAN:
				begin
					if (req.sel[0])
						d.chan_next = req.dat[3:0];
					// A request is dropped unless synth power is high.
					if (req.sel[1] && req.dat[pgd_pkg::CHAN_REQ_BIT] && synth_power_ctrl_o)
						d.chg = 1'b1;
				end
				pgd_pkg::ADR_IDENT:
				begin
					if (req.sel[0])
						d.ident[7:0] = req.dat[7:0];
					if (req.sel[1])
						d.ident[15:8] = req.dat[15:8];
				end
				pgd_pkg::ADR_OPTSEL:
					if (req.sel[0])
						d.optsel = req.dat[2:0];
				default:
					d.ctrl = d.ctrl;
			endcase
		end
		else if (req.cyc && req.stb && !q.ack)
		begin
			unique case (req.adr)
				pgd_pkg::ADR_CTRL:
					d.rdat = {24'h000000, q.ctrl};
				pgd_pkg::ADR_CHAN:
					d.rdat = {15'h0000, q.chg, 4'h0, q.chan, 4'h0, q.chan_next};
				pgd_pkg::ADR_MSG:
					d.rdat = {31'h0000_0000, q.mst != pgd_pkg::M_IDLE};
				pgd_pkg::ADR_IDENT:
					d.rdat = {16'h0000, q.ident};
				pgd_pkg::ADR_STATUS:
					d.rdat = {12'h000, q.on_s2, q.fr_s2, q.dm_s2, q.idx, 7'h00, q.loaded};
				pgd_pkg::ADR_OPTSEL:
					d.rdat = {29'h0000_0000, q.optsel};
				pgd_pkg::ADR_OPTWORD:
					d.rdat = (q.optsel < 3'h6) ? q.opts[{q.optsel, 5'h00} +: 32] : 32'h0000_0000;
				default:
					d.rdat = 32'h0000_0000;
			endcase
		end

		// Channel is fixed when synth power turns active.
		d.syn_prev = q.ctrl[pgd_pkg::CTRL_SYN_PWR];
		if (q.ctrl[pgd_pkg::CTRL_SYN_PWR] && !q.syn_prev)
			d.chan = q.chan_next;
		if (!synth_power_ctrl_o)
			d.chg = 1'b0;

		// LED square wave.
		if (q.opts[pgd_pkg::OPT_LED_FREQ])
			led_half = q.ctrl[pgd_pkg::CTRL_LED_UP] ? pgd_pkg::LED_HALF_40K : pgd_pkg::LED_HALF_10K;
		else
			led_half = q.ctrl[pgd_pkg::CTRL_LED_UP] ? pgd_pkg::LED_HALF_16K : pgd_pkg::LED_HALF_4K;
		if (!q.le_s2 || !q.on_s2)
		begin
			d.led = 1'b0;
			d.led_cnt = 11'h000;
		end
		else if (q.led_cnt >= led_half - 11'h001)
		begin
			d.led = ~q.led;
			d.led_cnt = 11'h000;
		end
		else
			d.led_cnt = q.led_cnt + 11'h001;

		// Message serializer.
		unique case ({q.opts[pgd_pkg::OPT_RATE_HI], q.opts[pgd_pkg::OPT_RATE_LO]})
			2'b00:   msg_half = pgd_pkg::MSG_HALF_0;
			2'b01:   msg_half = pgd_pkg::MSG_HALF_1;
			2'b10:   msg_half = pgd_pkg::MSG_HALF_2;
			2'b11:   msg_half = pgd_pkg::MSG_HALF_3;
		endcase
		unique case ({q.opts[pgd_pkg::OPT_GAP_HI], q.opts[pgd_pkg::OPT_GAP_LO]})
			2'b00:   gap_halves = pgd_pkg::GAP_HALVES_0;
			2'b01:   gap_halves = pgd_pkg::GAP_HALVES_1;
			2'b10:   gap_halves = pgd_pkg::GAP_HALVES_2;
			2'b11:   gap_halves = pgd_pkg::GAP_HALVES_3;
		endcase
		new_clk = ~q.mclk;
		unique case (q.mst)
			pgd_pkg::M_IDLE:
			begin
				d.mclk = opt_clk_idle;
				d.mdat = opt_dat_idle;
				// Bytes are only taken while message valid is active.
				if (wr && req.adr == pgd_pkg::ADR_MSG && req.sel[0]
					&& q.ctrl[pgd_pkg::CTRL_MSG_ACT] && q.on_s2)
				begin
					d.mst = pgd_pkg::M_SHIFT;
					d.mbyte = req.dat[7:0];
					d.mdat = req.dat[0];
					d.mbit = 3'h0;
					d.mtog = 5'h00;
					d.msampled = 1'b0;
					d.mcnt = 12'h000;
				end
			end
			pgd_pkg::M_SHIFT:
			begin
				if (q.mcnt >= msg_half - 12'h001)
				begin
					d.mcnt = 12'h000;
					d.mclk = new_clk;
					d.mtog = q.mtog + 5'h01;
					// Data changes only on the edge the host does not sample.
					if (new_clk == opt_edge)
						d.msampled = 1'b1;
					else if (q.msampled && q.mbit != 3'h7)
					begin
						d.mbit = q.mbit + 3'h1;
						d.mdat = q.mbyte[3'(q.mbit + 3'h1)];
						d.msampled = 1'b0;
					end
					if (q.mtog == pgd_pkg::BYTE_TOGGLES - 5'h01)
					begin
						d.mst = pgd_pkg::M_GAP;
						d.mtog = 5'h00;
					end
				end
				else if (q.on_s2)
					d.mcnt = q.mcnt + 12'h001;
			end
			pgd_pkg::M_GAP:
			begin
				if (q.mtog >= gap_halves)
				begin
					d.mst = pgd_pkg::M_IDLE;
					d.mdat = opt_dat_idle;
				end
				else if (q.mcnt >= msg_half - 12'h001)
				begin
					d.mcnt = 12'h000;
					d.mtog = q.mtog + 5'h01;
				end
				else if (q.on_s2)
					d.mcnt = q.mcnt + 12'h001;
			end
			default:
				d.mst = pgd_pkg::M_IDLE;
		endcase

		// Decoder reset pin clears the load and the serial engines.
		if (q.rst_s2)
		begin
			d.idx = 8'h00;
			d.loaded = 1'b0;
			d.ident_pos = 4'h0;
			d.chg = 1'b0;
			d.mst = pgd_pkg::M_IDLE;
			d.mclk = opt_clk_idle;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			q <= '0;
		else
			q <= d;
	end

	assign wb_ack_o                = q.ack;
	assign wb_dat_o                = q.rdat;
	assign option_serial_io_o      = q.sio;
	assign option_serial_io_oe_n_o = ~q.loaded;
	assign led_clock_out_o         = q.led;
	// A pin shows the active value when its level option bit is one.
	assign quick_charge_first_o    = ~(q.ctrl[pgd_pkg::CTRL_QCF] ^ q.opts[pgd_pkg::OPT_QCF_LEVEL]);
	assign quick_charge_second_o   = ~(q.ctrl[pgd_pkg::CTRL_QCS] ^ q.opts[pgd_pkg::OPT_QCS_LEVEL]);
	assign rf_ctrl_inverted_o      = ~quick_charge_second_o;
	assign receiver_power_ctrl_o   = ~(q.ctrl[pgd_pkg::CTRL_RX_PWR] ^ q.opts[pgd_pkg::OPT_RX_LEVEL]);
	assign synth_power_ctrl_o      = ~(q.ctrl[pgd_pkg::CTRL_SYN_PWR] ^ q.opts[pgd_pkg::OPT_SYN_LEVEL]);
	assign channel_change_req_o    = q.chg;
	assign sync_indicator_o        = ~q.ctrl[pgd_pkg::CTRL_SYNCED];
	assign own_address_hit_o       = q.ctrl[pgd_pkg::CTRL_ADDR_HIT];
	assign message_valid_o         = ~(q.ctrl[pgd_pkg::CTRL_MSG_ACT] ^ opt_valid_lvl);
	assign message_serial_out_o    = q.mdat;
	assign message_clock_o         = q.mclk;

	default clocking dc @(posedge clk_i); endclocking
	default disable iff (rst_i);

	opt_sample_a: assert property (
		oclk_rise && !q.loaded && !q.rst_s2 |=> q.opts[$past(q.idx)] == $past(q.sd_s2))
		else $error("option bit not captured");
	idx_advance_a: assert property (
		oclk_rise && !q.loaded && !q.rst_s2 |=> q.loaded || q.idx == $past(q.idx) + 8'h01)
		else $error("option index did not advance");
	pin_turn_a: assert property (
		$rose(q.loaded) |-> $past(q.idx) == pgd_pkg::OPT_LAST && !option_serial_io_oe_n_o)
		else $error("option pin turned at wrong bit");
	reset_index_a: assert property (
		q.rst_s2 |=> q.idx == 8'h00 && option_serial_io_oe_n_o)
		else $error("decoder reset did not clear load");
	rf_inverse_a: assert property (
		rf_ctrl_inverted_o != quick_charge_second_o)
		else $error("rf control not inverse of second quick charge");
	chan_latch_a: assert property (
		$rose(q.ctrl[pgd_pkg::CTRL_SYN_PWR]) |=> q.chan == $past(q.chan_next))
		else $error("channel not fixed at synth active edge");
	chg_gate_a: assert property (
		$rose(channel_change_req_o) |-> $past(synth_power_ctrl_o))
		else $error("channel change raised while synth power low");
	led_gate_a: assert property (
		!q.le_s2 |=> !led_clock_out_o)
		else $error("led clock running while disabled");
	msg_valid_a: assert property (
		q.mst == pgd_pkg::M_SHIFT && !q.rst_s2 |-> message_valid_o == opt_valid_lvl)
		else $error("message valid inactive during output");
	mclk_idle_a: assert property (
		q.mst == pgd_pkg::M_IDLE && $past(q.mst) == pgd_pkg::M_IDLE && $stable(opt_clk_idle)
		|-> message_clock_o == opt_clk_idle)
		else $error("message clock not parked at idle level");

endmodule : pgd_decoder_pins

`default_nettype wire

// ==== test/pgd_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module pgd_host_model (
	output logic ock_o,
	output logic odat_o
);
	initial
	begin
		ock_o = 1'b0;
		odat_o = 1'b0;
	end

	// The clock stands still low between frames; data moves only while it is low.
	task automatic send(input logic [191:0] v, input int s, input int n);
		for (int i = s; i < s + n; i++)
		begin
			odat_o <= v[i];
			#400 ock_o <= 1'b1;
			#400 ock_o <= 1'b0;
		end
	endtask : send
endmodule : pgd_host_model

`default_nettype wire

// ==== test/pgd_decoder_pins_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module pgd_decoder_pins_tb;
	logic         clk_i, rst_i, cyc, stb, we, on, drst, dl, dm, fr, len;
	logic [7:0]   adr;
	logic [31:0]  dat, rd, dout;
	logic         ack, ock, hd, so, oe_n, led, qc1, qc2, rfi, rxp, syp;
	logic         chg, syn, hit, mv, ms, mc;
	logic [191:0] opt;
	int           errors, compares;
	wire logic    sio = oe_n ? hd : so;

	pgd_host_model hm (.ock_o(ock), .odat_o(hd));

	pgd_decoder_pins u_pgd_decoder_pins (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_sel_i(4'hF), .wb_adr_i(adr), .wb_dat_i(dat),
		.wb_ack_o(ack), .wb_dat_o(dout), .chip_on_i(on),
		.decoder_reset_in_i(drst), .option_load_clock_i(ock),
		.option_serial_io_i(sio), .option_serial_io_o(so),
		.option_serial_io_oe_n_o(oe_n), .demod_lsb_in_i(dl),
		.demod_msb_in_i(dm), .forced_roaming_in_i(fr),
		.led_clock_enable_i(len), .led_clock_out_o(led),
		.quick_charge_first_o(qc1), .quick_charge_second_o(qc2),
		.rf_ctrl_inverted_o(rfi), .receiver_power_ctrl_o(rxp),
		.synth_power_ctrl_o(syp), .channel_change_req_o(chg),
		.sync_indicator_o(syn), .own_address_hit_o(hit),
		.message_valid_o(mv), .message_serial_out_o(ms),
		.message_clock_o(mc)
	);

	initial
	begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	task automatic end_of_test();
		if (errors == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			errors++;
			$display("[ERR] %0t exp %h got %h", $time, e, g);
		end
	endtask : chk

	// The request stands until a rising edge samples ack high; read data is taken at that edge.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		@(posedge clk_i);
		while (ack !== 1'b1 && n < 50)
		begin
			@(posedge clk_i);
			n++;
		end
		if (ack !== 1'b1)
		begin
			errors++;
			$display("[ERR] %0t exp %h got %h", $time, 1'b1, ack);
		end
		rd = dout;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : wb

	function automatic logic pick(input int s);
		return s ? mc : led;
	endfunction : pick

	task automatic hi_len(input int s, output int n);
		int t;
		t = 0;
		n = 0;
		while (pick(s) !== 1'b0 && t < 5000)
		begin
			@(negedge clk_i);
			t++;
		end
		while (pick(s) !== 1'b1 && t < 5000)
		begin
			@(negedge clk_i);
			t++;
		end
		while (pick(s) === 1'b1 && t < 5000)
		begin
			@(negedge clk_i);
			t++;
			n++;
		end
	endtask : hi_len

	task automatic t_reset();
		@(negedge clk_i);
		chk(32'hEE8, {oe_n, qc1, qc2, rfi, rxp, syp, syn, hit, mv, led, mc, ms});
		wb(1'b0, pgd_pkg::ADR_STATUS, 32'h0);
		chk(32'h0, 32'(rd[15:0]));
	endtask : t_reset

	task automatic t_load();
		wb(1'b1, pgd_pkg::ADR_IDENT, 32'h1);
		hm.send(opt, 0, 10);
		repeat (8) @(negedge clk_i);
		wb(1'b0, pgd_pkg::ADR_STATUS, 32'h0);
		chk(32'hA, 32'(rd[15:8]));
		hm.send(opt, 10, 182);
		repeat (8) @(negedge clk_i);
		chk(32'h0, 32'(oe_n));
		chk(32'h1, 32'(sio));
		hm.send(opt, 0, 1);
		repeat (8) @(negedge clk_i);
		chk(32'h0, 32'(sio));
		for (int i = 0; i < 6; i++)
		begin
			wb(1'b1, pgd_pkg::ADR_OPTSEL, 32'(i));
			wb(1'b0, pgd_pkg::ADR_OPTWORD, 32'h0);
			chk(opt[i*32 +: 32], rd);
		end
		wb(1'b0, 8'h1C, 32'h0);
		chk(32'h0, rd);
	endtask : t_load

	task automatic t_pins();
		logic [5:0] v;
		for (int i = 0; i < 64; i++)
		begin
			v = 6'(i);
			wb(1'b1, pgd_pkg::ADR_CTRL, 32'(v));
			@(negedge clk_i);
			chk({v[0], v[1], v[2], ~v[3], v[3], ~v[4], v[5]},
				{rxp, syp, qc1, qc2, rfi, syn, hit});
		end
	endtask : t_pins

	task automatic t_chan();
		wb(1'b1, pgd_pkg::ADR_CTRL, 32'h0);
		wb(1'b1, pgd_pkg::ADR_CHAN, 32'h105);
		repeat (3) @(negedge clk_i);
		chk(32'h0, 32'(chg));
		wb(1'b1, pgd_pkg::ADR_CTRL, 32'h2);
		repeat (3) @(negedge clk_i);
		wb(1'b0, pgd_pkg::ADR_CHAN, 32'h0);
		chk(32'h5, 32'(rd[11:8]));
		wb(1'b1, pgd_pkg::ADR_CHAN, 32'h105);
		repeat (3) @(negedge clk_i);
		chk(32'h1, 32'(chg));
		wb(1'b1, pgd_pkg::ADR_CTRL, 32'h0);
		repeat (3) @(negedge clk_i);
		chk(32'h0, 32'(chg));
	endtask : t_chan

	task automatic t_demod();
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clk_i);
			dm <= i[1];
			dl <= i[0];
			fr <= i[0];
			repeat (5) @(posedge clk_i);
			wb(1'b0, pgd_pkg::ADR_STATUS, 32'h0);
			chk({1'b1, i[0], i[1:0]}, 32'(rd[19:16]));
		end
	endtask : t_demod

	task automatic t_led();
		int n;
		@(posedge clk_i);
		len <= 1'b1;
		hi_len(0, n);
		chk(32'(pgd_pkg::LED_HALF_10K), 32'(n));
		wb(1'b1, pgd_pkg::ADR_CTRL, 32'h80);
		hi_len(0, n);
		hi_len(0, n);
		chk(32'(pgd_pkg::LED_HALF_40K), 32'(n));
		@(posedge clk_i);
		on <= 1'b0;
		repeat (8) @(negedge clk_i);
		hi_len(0, n);
		chk(32'h0, 32'(n));
		@(posedge clk_i);
		on <= 1'b1;
		len <= 1'b0;
		repeat (8) @(negedge clk_i);
		hi_len(0, n);
		chk(32'h0, 32'(n));
	endtask : t_led

	task automatic t_msg();
		logic [7:0] b;
		int t;
		wb(1'b1, pgd_pkg::ADR_CTRL, 32'h0);
		chk(32'h0, 32'(mv));
		wb(1'b1, pgd_pkg::ADR_CTRL, 32'h40);
		@(negedge clk_i);
		chk(32'h2, {mv, mc});
		wb(1'b1, pgd_pkg::ADR_MSG, 32'hA5);
		for (int i = 0; i < 8; i++)
		begin
			t = 0;
			while (mc !== 1'b0 && t < 2000)
			begin
				@(negedge clk_i);
				t++;
			end
			while (mc !== 1'b1 && t < 2000)
			begin
				@(negedge clk_i);
				t++;
			end
			b[i] = ms;
			if (i > 0)
				chk(2 * pgd_pkg::MSG_HALF_3, 32'(t));
			chk(32'h1, 32'(mv));
		end
		chk(32'hA5, 32'(b));
		t = 0;
		rd = 32'h1;
		while (rd[0] !== 1'b0 && t < 40)
		begin
			repeat (50) @(posedge clk_i);
			wb(1'b0, pgd_pkg::ADR_MSG, 32'h0);
			t++;
		end
		chk(32'h0, {rd[0], mc, ms});
	endtask : t_msg

	task automatic t_drst();
		@(posedge clk_i);
		drst <= 1'b1;
		repeat (6) @(posedge clk_i);
		drst <= 1'b0;
		repeat (6) @(negedge clk_i);
		chk(32'h1, 32'(oe_n));
		wb(1'b0, pgd_pkg::ADR_STATUS, 32'h0);
		chk(32'h0, 32'(rd[15:0]));
	endtask : t_drst

	initial
	begin
		#4_000_000;
		errors++;
		end_of_test();
	end

	initial
	begin
		{rst_i, on} = 2'b11;
		{cyc, stb, we, drst, dl, dm, fr, len} = 8'h00;
		adr = 8'h00;
		dat = 32'h0;
		errors = 0;
		compares = 0;
		opt = {6{32'hC3A5_96E1}};
		// Rising-edge data, high levels except second quick-charge, fastest rate, upper pair.
		opt[127:104] = 24'h02C63C;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_load();
		t_pins();
		t_chan();
		t_demod();
		t_led();
		t_msg();
		t_drst();
		end_of_test();
	end
endmodule : pgd_decoder_pins_tb

`default_nettype wire
